// >>> logic/dsa_map.svh
`ifndef DSA_MAP_SVH
`define DSA_MAP_SVH
`define DSA_ROW_MSB_X8  14
`define DSA_ROW_MSB_X16 13
`define DSA_ROW_MSB     `DSA_ROW_MSB_X8
`define DSA_DQ_W        8
`define DSA_BANK_W      3
`define DSA_BANKS       8
`define DSA_MEM_AW      8
`define DSA_MEM_WORDS   256
`define DSA_BL8         4'h8
`define DSA_BC4         4'h4
`define DSA_RD_LAT      3'h5
`define DSA_AP_BIT      10
`define DSA_CHOP_BIT    12
`define DSA_PRE_DQS     2'h0
`define DSA_PRE_DQS_N   2'h3
`define DSA_DAT_DQS     2'h2
`define DSA_DAT_DQS_N   2'h1
`endif

// >>> logic/dsa_pkg.sv
`include "dsa_map.svh"
package dsa_pkg;
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS
  } dsa_cmd_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RD_WAIT, ST_RD_PRE, ST_RD_DATA, ST_WR_WAIT, ST_WR_DATA
  } dsa_state_t;
  typedef struct packed {
    logic [`DSA_DQ_W-1:0] rise;
    logic [`DSA_DQ_W-1:0] fall;
  } dsa_beats_t;
  typedef struct packed {
    logic                   cs_n;
    logic                   ras_n;
    logic                   cas_n;
    logic                   we_n;
    logic                   cke;
    logic [`DSA_BANK_W-1:0] bank;
    logic [`DSA_ROW_MSB:0]  addr;
  } dsa_pins_t;
  typedef struct packed {
    logic [1:0]                        cfg_s1;
    logic [1:0]                        cfg_s2;
    dsa_pins_t                         pins;
    logic                              cke_q;
    dsa_beats_t                        dqi;
    logic [1:0]                        dmi;
    logic [1:0]                        dqsi;
    logic [1:0]                        dqsni;
    logic                              self_ref;
    logic                              pwr_down;
    logic [`DSA_BANKS-1:0]             open;
    logic [`DSA_BANKS-1:0][`DSA_ROW_MSB:0] rows;
    dsa_state_t                        st;
    logic [2:0]                        cnt;
    logic [3:0]                        beat;
    logic                              chop;
    logic                              ap;
    logic [`DSA_BANK_W-1:0]            bank;
    logic [9:0]                        col;
    logic                              pre_seen;
    dsa_beats_t                        dq_out;
    logic [1:0]                        dqs_out;
    logic                              dqs_oe;
    logic                              done_tgl;
  } dsa_link_t;
  typedef struct packed {
    logic       sr_s1;
    logic       sr_s2;
    logic       pd_s1;
    logic       pd_s2;
    logic       tg_s1;
    logic       tg_s2;
    logic       tg_s3;
    logic [7:0] count;
  } dsa_core_t;
endpackage

// >>> logic/dsa_access.sv
// Summary of operation
// RL1: Two data words per clock, prefetch eight.
// RL2: One access spans four clocks, eight beats.
// RL3: Controller centres write strobe in data window.
// RL4: Read data driven edge-aligned with strobe.
// RL5: Commands registered on every positive clock edge.
// RL6: First write beat after write preamble.
// RL7: First read beat after read preamble.
// RL8: Controller activates row before read or write.
// RL9: Activate selects bank and row.
// RL10: Read/write selects bank and start column.
// RL11: Burst walks columns in programmed order.
// RL12: Bursts of eight and chopped four.
// RL13: Auto precharge closes row after burst.
// RL14: Banks activate and precharge during bursts.
// RL15: Controller doubles refresh above 85 C.
// RL16: Row width depends on organisation.
// RL17: Self refresh and power-down modes provided.
// RL18: Chop bit high eight, low four.
// RL19: Precharge bit requests auto precharge.
// RL20: Commands ignored while chip select high.
// RL21: Masked write beats are not stored.
// RL22: Controller keeps activate and precharge spacing.
`timescale 1ns/1ps
`include "dsa_map.svh"
module dsa_access (
  // Core clock and reset
  input  wire logic                       I_CLOCK,
  input  wire logic                       I_RESET_N,
  // Link clock, true phase of the differential pair
  input  wire logic                       I_SYS_CLK_PAIR,
  // Command and address
  input  wire logic                       I_CS_N,
  input  wire logic                       I_RAS_N,
  input  wire logic                       I_CAS_N,
  input  wire logic                       I_WE_N,
  input  wire logic                       I_CKE,
  input  wire logic [`DSA_BANK_W-1:0]     I_BANK,
  input  wire logic [`DSA_ROW_MSB:0]      I_ADDR,
  // Data lines, rise and fall halves
  input  wire logic [`DSA_DQ_W-1:0]       I_DQ_RISE,
  input  wire logic [`DSA_DQ_W-1:0]       I_DQ_FALL,
  output logic      [`DSA_DQ_W-1:0]       O_DQ_RISE,
  output logic      [`DSA_DQ_W-1:0]       O_DQ_FALL,
  output logic                            O_DQ_OE,
  input  wire logic [1:0]                 I_WRITE_MASK,
  // Strobe pair, rise and fall halves
  input  wire logic [1:0]                 I_DQS,
  input  wire logic [1:0]                 I_DQS_N,
  output logic      [1:0]                 O_DQS,
  output logic      [1:0]                 O_DQS_N,
  output logic                            O_DQS_OE,
  // Static configuration
  input  wire logic                       I_OTF_EN,
  input  wire logic                       I_INTERLEAVE,
  // Core-side status
  output logic                            O_SELF_REFRESH,
  output logic                            O_POWER_DOWN,
  output logic      [7:0]                 O_ACCESS_COUNT
);

  function automatic logic [2:0] dsa_beat_col(input logic [2:0] start,
                                              input logic [2:0] k,
                                              input logic       il,
                                              input logic       chop);
    logic [2:0] r;
    r = il ? (start ^ k) : (start + k);
    if (chop) begin
      r[2] = start[2];
    end
    return r;
  endfunction

  function automatic logic [`DSA_MEM_AW-1:0] dsa_addr(input dsa_pkg::dsa_link_t v,
                                                      input logic [2:0] k);
    dsa_addr = {v.bank, v.rows[v.bank][0], v.col[3],
                dsa_beat_col(v.col[2:0], k, v.cfg_s2[0], v.chop)}; // [RL11]
  endfunction

  function automatic dsa_pkg::dsa_cmd_t dsa_decode(input dsa_pkg::dsa_pins_t p);
    if (p.cs_n) begin
      return dsa_pkg::CMD_NOP; // [RL20]
    end
    unique case ({p.ras_n, p.cas_n, p.we_n})
      3'h3:    return dsa_pkg::CMD_ACT;
      3'h5:    return dsa_pkg::CMD_RD;
      3'h4:    return dsa_pkg::CMD_WR;
      3'h2:    return dsa_pkg::CMD_PRE;
      3'h1:    return dsa_pkg::CMD_REF;
      3'h0:    return dsa_pkg::CMD_MRS;
      default: return dsa_pkg::CMD_NOP;
    endcase
  endfunction

  // Release of reset is resynchronised to the link clock
  logic [1:0]                 link_rst_sync;
  logic                       link_rst_n;
  always_ff @(posedge I_SYS_CLK_PAIR or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      link_rst_sync <= 2'h0;
    end else begin
      link_rst_sync <= {link_rst_sync[0], 1'b1};
    end
  end
  assign link_rst_n = link_rst_sync[1];

  dsa_pkg::dsa_link_t         s;
  dsa_pkg::dsa_link_t         next_s;
  dsa_pkg::dsa_cmd_t          cmd;
  logic                       awake;
  logic                       wr_strobe;
  logic                       wr_pre;
  logic [3:0]                 len;
  logic [2:0]                 k1;
  logic [1:0]                 mem_we;
  logic [`DSA_MEM_AW-1:0]     a0;
  logic [`DSA_MEM_AW-1:0]     a1;
  logic [`DSA_DQ_W-1:0]       mem [`DSA_MEM_WORDS];

  assign cmd       = dsa_decode(s.pins);
  assign awake     = !s.self_ref && !s.pwr_down && s.pins.cke;
  assign wr_pre    = s.dqsi == `DSA_PRE_DQS && s.dqsni == `DSA_PRE_DQS_N;
  assign wr_strobe = s.dqsi == `DSA_DAT_DQS && s.dqsni == `DSA_DAT_DQS_N;
  assign len       = s.chop ? `DSA_BC4 : `DSA_BL8; // [RL12]
  assign k1        = s.beat[2:0] + 3'h1;
  assign a0        = dsa_addr(s, s.beat[2:0]);
  assign a1        = dsa_addr(s, k1);

  always_comb begin
    next_s = s;
    mem_we = 2'h0;
    next_s.cfg_s1 = {I_OTF_EN, I_INTERLEAVE};
    next_s.cfg_s2 = s.cfg_s1;
    next_s.pins = {I_CS_N, I_RAS_N, I_CAS_N, I_WE_N, I_CKE, I_BANK, I_ADDR}; // [RL5]
    next_s.cke_q = s.pins.cke;
    next_s.dqi = {I_DQ_RISE, I_DQ_FALL};
    next_s.dmi = I_WRITE_MASK;
    next_s.dqsi = I_DQS;
    next_s.dqsni = I_DQS_N;
    // Power states; power-down is only entered with no burst in flight
    if (s.self_ref || s.pwr_down) begin
      if (s.pins.cke) begin
        next_s.self_ref = 1'b0; // [RL17]
        next_s.pwr_down = 1'b0;
      end
    end else if (!s.pins.cke && s.cke_q) begin
      if (cmd == dsa_pkg::CMD_REF) begin
        next_s.self_ref = 1'b1; // [RL17]
      end else if (s.st == dsa_pkg::ST_IDLE) begin
        next_s.pwr_down = 1'b1;
      end
    end
    // Bank commands run independently of the data engine
    if (awake) begin
      unique case (cmd)
        dsa_pkg::CMD_ACT: begin
          if (!s.open[s.pins.bank]) begin
            next_s.open[s.pins.bank] = 1'b1; // [RL9] [RL14]
            next_s.rows[s.pins.bank] = s.pins.addr; // [RL16]
          end
        end
        dsa_pkg::CMD_PRE: begin
          if (s.pins.addr[`DSA_AP_BIT]) begin
            next_s.open = '0;
          end else begin
            next_s.open[s.pins.bank] = 1'b0; // [RL14]
          end
        end
        dsa_pkg::CMD_RD, dsa_pkg::CMD_WR: begin
          // A new access is dropped while a burst is still running
          if (s.st == dsa_pkg::ST_IDLE && s.open[s.pins.bank]) begin
            next_s.bank = s.pins.bank; // [RL10]
            next_s.col = s.pins.addr[9:0];
            next_s.ap = s.pins.addr[`DSA_AP_BIT]; // [RL19]
            next_s.chop = s.cfg_s2[1] && !s.pins.addr[`DSA_CHOP_BIT]; // [RL18]
            next_s.cnt = `DSA_RD_LAT;
            next_s.beat = 4'h0;
            next_s.pre_seen = 1'b0;
            next_s.st = (cmd == dsa_pkg::CMD_RD) ? dsa_pkg::ST_RD_WAIT
                                                 : dsa_pkg::ST_WR_WAIT;
          end
        end
        default: begin
        end
      endcase
    end
    // Data engine: two beats per clock, four clocks per full burst
    unique case (s.st)
      dsa_pkg::ST_IDLE: begin
      end
      dsa_pkg::ST_RD_WAIT: begin
        next_s.cnt = s.cnt - 3'h1;
        if (s.cnt == 3'h1) begin
          next_s.st = dsa_pkg::ST_RD_PRE;
          next_s.dqs_oe = 1'b1;
          next_s.dqs_out = `DSA_PRE_DQS; // [RL7]
        end
      end
      dsa_pkg::ST_RD_PRE, dsa_pkg::ST_RD_DATA: begin
        if (s.st == dsa_pkg::ST_RD_DATA && s.beat == len) begin
          next_s.st = dsa_pkg::ST_IDLE;
          next_s.dqs_oe = 1'b0;
          next_s.dqs_out = `DSA_PRE_DQS;
          next_s.done_tgl = !s.done_tgl;
          if (s.ap) begin
            next_s.open[s.bank] = 1'b0; // [RL13]
          end
        end else begin
          next_s.st = dsa_pkg::ST_RD_DATA;
          next_s.dq_out.rise = mem[a0]; // [RL1] [RL4]
          next_s.dq_out.fall = mem[a1];
          next_s.dqs_out = `DSA_DAT_DQS; // [RL4]
          next_s.beat = s.beat + 4'h2; // [RL2]
        end
      end
      dsa_pkg::ST_WR_WAIT: begin
        if (s.pre_seen && wr_strobe) begin
          mem_we = ~s.dmi; // [RL6] [RL21]
          next_s.beat = 4'h2;
          next_s.st = dsa_pkg::ST_WR_DATA;
        end else if (wr_pre) begin
          next_s.pre_seen = 1'b1; // [RL6]
        end
      end
      dsa_pkg::ST_WR_DATA: begin
        // A gap in the strobe simply stalls the burst
        if (wr_strobe) begin
          mem_we = ~s.dmi; // [RL21]
          next_s.beat = s.beat + 4'h2; // [RL2]
          if (s.beat + 4'h2 == len) begin
            next_s.st = dsa_pkg::ST_IDLE;
            next_s.done_tgl = !s.done_tgl;
            if (s.ap) begin
              next_s.open[s.bank] = 1'b0; // [RL13]
            end
          end
        end
      end
      default: begin
        next_s.st = dsa_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_SYS_CLK_PAIR or negedge link_rst_n) begin
    if (!link_rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Array has no reset; contents are undefined until written
  always_ff @(posedge I_SYS_CLK_PAIR) begin
    if (mem_we[0]) begin
      mem[a0] <= s.dqi.rise;
    end
    if (mem_we[1]) begin
      mem[a1] <= s.dqi.fall;
    end
  end

  assign O_DQ_RISE = s.dq_out.rise;
  assign O_DQ_FALL = s.dq_out.fall;
  assign O_DQ_OE   = s.dqs_oe && s.st == dsa_pkg::ST_RD_DATA;
  assign O_DQS     = s.dqs_out;
  assign O_DQS_N   = ~s.dqs_out;
  assign O_DQS_OE  = s.dqs_oe;

  // Core domain: levels through two flops, burst ends as a toggle
  dsa_pkg::dsa_core_t         c;
  dsa_pkg::dsa_core_t         next_c;

  always_comb begin
    next_c = c;
    next_c.sr_s1 = s.self_ref;
    next_c.sr_s2 = c.sr_s1;
    next_c.pd_s1 = s.pwr_down;
    next_c.pd_s2 = c.pd_s1;
    next_c.tg_s1 = s.done_tgl;
    next_c.tg_s2 = c.tg_s1;
    next_c.tg_s3 = c.tg_s2;
    if (c.tg_s3 != c.tg_s2) begin
      next_c.count = c.count + 8'h01;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      c <= '0;
    end else begin
      c <= next_c;
    end
  end

  assign O_SELF_REFRESH = c.sr_s2;
  assign O_POWER_DOWN   = c.pd_s2;
  assign O_ACCESS_COUNT = c.count;

  a_bl8_span: assert property (@(posedge I_SYS_CLK_PAIR) disable iff (!link_rst_n) // [RL2]
    $rose(O_DQS_OE) && !s.chop |-> O_DQS_OE [*5] ##1 !O_DQS_OE)
    else $error("full read burst not four data clocks");
  a_bc4_span: assert property (@(posedge I_SYS_CLK_PAIR) disable iff (!link_rst_n) // [RL12]
    $rose(O_DQS_OE) && s.chop |-> O_DQS_OE [*3] ##1 !O_DQS_OE)
    else $error("chopped read burst not two data clocks");
  a_read_pre: assert property (@(posedge I_SYS_CLK_PAIR) disable iff (!link_rst_n) // [RL7]
    $rose(O_DQS_OE) |-> O_DQS == 2'h0 && !O_DQ_OE ##1 O_DQS == 2'h2 && O_DQ_OE)
    else $error("read preamble missing");
  a_read_edge: assert property (@(posedge I_SYS_CLK_PAIR) disable iff (!link_rst_n) // [RL4]
    O_DQ_OE |-> O_DQS_OE && O_DQS == 2'h2 && O_DQS_N == 2'h1)
    else $error("read data without strobe edge");
  a_rd_latency: assert property (@(posedge I_SYS_CLK_PAIR) disable iff (!link_rst_n) // [RL10]
    s.st == dsa_pkg::ST_RD_WAIT && $past(s.st) == dsa_pkg::ST_IDLE
    |-> ##5 s.st == dsa_pkg::ST_RD_PRE)
    else $error("read latency wrong");
  a_cs_mask: assert property (@(posedge I_SYS_CLK_PAIR) disable iff (!link_rst_n) // [RL20]
    s.pins.cs_n && s.st == dsa_pkg::ST_IDLE |=> s.st == dsa_pkg::ST_IDLE && $stable(s.open))
    else $error("deselected command acted on");
  a_act_open: assert property (@(posedge I_SYS_CLK_PAIR) disable iff (!link_rst_n) // [RL9]
    awake && cmd == dsa_pkg::CMD_ACT && !s.open[s.pins.bank]
    |=> s.open[$past(s.pins.bank)] && s.rows[$past(s.pins.bank)] == $past(s.pins.addr))
    else $error("activate did not open row");
  a_auto_pre: assert property (@(posedge I_SYS_CLK_PAIR) disable iff (!link_rst_n) // [RL13]
    s.st == dsa_pkg::ST_RD_DATA && s.beat == len && s.ap |=> !s.open[$past(s.bank)])
    else $error("auto precharge left row open");
  a_wr_first: assert property (@(posedge I_SYS_CLK_PAIR) disable iff (!link_rst_n) // [RL6]
    s.st == dsa_pkg::ST_WR_WAIT && !s.pre_seen |=> s.st == dsa_pkg::ST_WR_WAIT)
    else $error("write captured before preamble");
  a_mask_keep: assert property (@(posedge I_SYS_CLK_PAIR) disable iff (!link_rst_n) // [RL21]
    s.st == dsa_pkg::ST_WR_DATA && wr_strobe && s.dmi == 2'h3 |=> mem[$past(a0)] == $past(mem[a0]))
    else $error("masked beat was stored");

endmodule

// >>> dv/dsa_ctrl_model.sv
`timescale 1ns/1ps
`include "dsa_map.svh"
module dsa_ctrl_model (
  // Link clock
  input  wire logic          i_lclk,
  // Command, write data and strobe
  output dsa_pkg::dsa_pins_t  o_pins,
  output dsa_pkg::dsa_beats_t o_dq,
  output logic [1:0]          o_mask,
  output logic [1:0]          o_dqs,
  output logic [1:0]          o_dqs_n
);
  initial begin
    o_pins = '0;
    {o_pins.cs_n, o_pins.ras_n, o_pins.cas_n, o_pins.we_n, o_pins.cke} = 5'h1f;
    o_dq = '0;
    o_mask = 2'h0;
    o_dqs = 2'h1;
    o_dqs_n = 2'h2;
  end
  // One command cycle, code is {cs_n, ras_n, cas_n, we_n}; cke stays as given
  task automatic cmd(input logic [3:0] c, input logic [`DSA_BANK_W-1:0] b,
                     input logic [`DSA_ROW_MSB:0] a, input logic ck);
    @(posedge i_lclk);
    {o_pins.cs_n, o_pins.ras_n, o_pins.cas_n, o_pins.we_n} <= c;
    o_pins.bank <= b;
    o_pins.addr <= a;
    o_pins.cke  <= ck;
    @(posedge i_lclk);
    {o_pins.cs_n, o_pins.ras_n, o_pins.cas_n, o_pins.we_n} <= 4'h7;
    // Address no longer held: show the inverse, not a stale copy
    o_pins.bank <= ~b;
    o_pins.addr <= ~a;
  endtask
  // Preamble, then strobed cycles; on the wire the edges sit mid-window
  task automatic wr_data(input logic [63:0] d, input logic [7:0] m, input int n);
    @(posedge i_lclk);
    o_dqs   <= 2'h0;
    o_dqs_n <= 2'h3;
    for (int i = 0; i < n; i++) begin
      @(posedge i_lclk);
      o_dqs   <= 2'h2;
      o_dqs_n <= 2'h1;
      o_dq    <= {d[16*i+:8], d[16*i+8+:8]};
      o_mask  <= {m[2*i+1], m[2*i]};
    end
    @(posedge i_lclk);
    o_dqs   <= 2'h1;
    o_dqs_n <= 2'h2;
    o_dq    <= ~o_dq;
  endtask
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`include "dsa_map.svh"
module tb_top;
  logic                clk = 1'b0;
  logic                lclk = 1'b0;
  logic                rst_n = 1'b0;
  logic                otf = 1'b1;
  logic                il = 1'b0;
  dsa_pkg::dsa_pins_t  pins;
  dsa_pkg::dsa_beats_t dq_w;
  logic [7:0]          rd_rise, rd_fall, acc_cnt;
  logic [1:0]          mask, dqs_w, dqsn_w, dqs_r, dqsn_r;
  logic                dq_oe, dqs_oe, self_ref, pwr_down;
  logic [7:0]          mem [256];
  logic                r0 [8];
  dsa_pkg::dsa_beats_t exp_q [$];
  int                  fails = 0;
  int                  check_count = 0;
  int                  bursts = 0;
  always #12.5 clk = ~clk;
  // Link clock runs free, phase unrelated to the core clock
  initial begin
    #3;
    forever #7.5 lclk = ~lclk;
  end
  dsa_access uut (
    .I_CLOCK(clk), .I_RESET_N(rst_n), .I_SYS_CLK_PAIR(lclk),
    .I_CS_N(pins.cs_n), .I_RAS_N(pins.ras_n), .I_CAS_N(pins.cas_n), .I_WE_N(pins.we_n),
    .I_CKE(pins.cke), .I_BANK(pins.bank), .I_ADDR(pins.addr),
    .I_DQ_RISE(dq_w.rise), .I_DQ_FALL(dq_w.fall), .O_DQ_RISE(rd_rise),
    .O_DQ_FALL(rd_fall), .O_DQ_OE(dq_oe), .I_WRITE_MASK(mask), .I_DQS(dqs_w),
    .I_DQS_N(dqsn_w), .O_DQS(dqs_r), .O_DQS_N(dqsn_r), .O_DQS_OE(dqs_oe),
    .I_OTF_EN(otf), .I_INTERLEAVE(il), .O_SELF_REFRESH(self_ref),
    .O_POWER_DOWN(pwr_down), .O_ACCESS_COUNT(acc_cnt));
  dsa_ctrl_model ctrl (.i_lclk(lclk), .o_pins(pins), .o_dq(dq_w), .o_mask(mask),
                       .o_dqs(dqs_w), .o_dqs_n(dqsn_w));
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[FAIL] t=%0t %s", $time, msg);
    end
  endtask
  // Memory slot of beat k of a burst starting at column c
  function automatic logic [7:0] idx(input logic [2:0] b, input logic [9:0] c,
                                     input logic [2:0] k, input logic ch);
    logic [2:0] o;
    o = il ? (c[2:0] ^ k) : (ch ? {c[2], c[1:0] + k[1:0]} : c[2:0] + k);
    return {b, r0[b], c[3], o};
  endfunction
  // Read results are taken off the queue as they appear
  always @(negedge lclk) begin
    if (dqs_oe === 1'b1) chk(dqsn_r === ~dqs_r, "strobe pair");
    if (dq_oe === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0, "read data not expected");
      else chk(exp_q.pop_front() === {rd_rise, rd_fall} && dqs_r === 2'h2, "read beats");
    end
  end
  task automatic act(input logic [2:0] b, input logic [14:0] r);
    r0[b] = r[0];
    ctrl.cmd(4'h3, b, r, 1'b1);
    repeat (3) @(posedge lclk);
  endtask
  task automatic wr(input logic [2:0] b, input logic [9:0] c, input logic [63:0] d,
                    input logic [7:0] m);
    for (int k = 0; k < 8; k++)
      if (!m[k]) mem[idx(b, c, 3'(k), 1'b0)] = d[8*k+:8];
    ctrl.cmd(4'h4, b, {2'h0, 3'h4, c}, 1'b1);
    ctrl.wr_data(d, m, 4);
    repeat (2) @(posedge lclk);
    bursts++;
  endtask
  task automatic rd(input logic [2:0] b, input logic [9:0] c, input logic ch,
                    input logic ap, input logic ok);
    int n;
    n = (ch && otf) ? 2 : 4;
    if (ok)
      for (int k = 0; k < 2 * n; k += 2)
        exp_q.push_back({mem[idx(b, c, 3'(k), ch && otf)], mem[idx(b, c, 3'(k + 1), ch && otf)]});
    ctrl.cmd(4'h5, b, {2'h0, ~ch, 1'b0, ap, c}, 1'b1);
    if (!ok) repeat (14) @(posedge lclk);
    else begin
      // Preamble shows six link edges after the command is registered
      repeat (5) @(posedge lclk);
      @(negedge lclk);
      chk(dqs_oe === 1'b0, "early preamble");
      @(negedge lclk);
      chk(dqs_oe === 1'b1 && dq_oe === 1'b0 && dqs_r === 2'h0, "read preamble");
      repeat (n + 1) @(negedge lclk);
      chk(dq_oe === 1'b0 && exp_q.size() == 0, "burst length");
      bursts++;
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict();
  end
  initial begin
    logic [2:0] b, b2;
    logic [9:0] c;
    void'($urandom(32'h38625205));
    b = 3'($urandom);
    b2 = b ^ 3'h5;
    c = 10'($urandom);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge lclk);
    act(b, 15'($urandom));
    wr(b, c, {$urandom, $urandom}, 8'h00);
    rd(b, c, 1'b0, 1'b0, 1'b1);
    wr(b, c, {$urandom, $urandom}, 8'($urandom) | 8'h30);
    rd(b, c, 1'b0, 1'b0, 1'b1);
    rd(b, c, 1'b1, 1'b0, 1'b1);
    $display("test sequential bursts done");
    @(posedge clk) il <= 1'b1;
    repeat (4) @(posedge lclk);
    rd(b, c, 1'b0, 1'b0, 1'b1);
    rd(b, c, 1'b1, 1'b0, 1'b1);
    @(posedge clk) il <= 1'b0;
    @(posedge clk) otf <= 1'b0;
    repeat (4) @(posedge lclk);
    rd(b, c, 1'b1, 1'b0, 1'b1);
    @(posedge clk) otf <= 1'b1;
    $display("test burst order and chop done");
    fork
      rd(b, c, 1'b0, 1'b0, 1'b1);
      begin
        repeat (3) @(posedge lclk);
        act(b2, 15'($urandom));
      end
    join
    wr(b2, c, {$urandom, $urandom}, 8'h00);
    rd(b2, c, 1'b0, 1'b0, 1'b1);
    ctrl.cmd(4'hd, b2, {5'h00, c}, 1'b1);
    repeat (14) @(posedge lclk);
    rd(b, c, 1'b0, 1'b1, 1'b1);
    rd(b, c, 1'b0, 1'b0, 1'b0);
    repeat (12) @(posedge clk);
    chk(acc_cnt === 8'(bursts), "burst count");
    $display("test banks and precharge done");
    // Hot case: refresh interval halved, so two refreshes per slot
    repeat (2) ctrl.cmd(4'h1, 3'h0, 15'h0, 1'b1);
    repeat (4) @(posedge clk);
    chk(self_ref === 1'b0 && pwr_down === 1'b0, "refresh while awake");
    ctrl.cmd(4'h2, 3'h0, 15'h0400, 1'b1);
    repeat (3) @(posedge lclk);
    ctrl.cmd(4'h7, 3'h0, 15'h0, 1'b0);
    repeat (8) @(posedge clk);
    chk(pwr_down === 1'b1 && self_ref === 1'b0, "power-down entry");
    ctrl.cmd(4'h7, 3'h0, 15'h0, 1'b1);
    repeat (8) @(posedge clk);
    chk(pwr_down === 1'b0, "power-down exit");
    ctrl.cmd(4'h1, 3'h0, 15'h0, 1'b0);
    repeat (8) @(posedge clk);
    chk(self_ref === 1'b1, "self refresh entry");
    $display("test power states done");
    print_verdict();
  end
endmodule
